// ### verilog/twc_top.v
// Purpose: two-wire interface common control, registers, interrupts, client link
// Assumes: Avalon-MM slave on sys_clk; sleep and dbg_halt come from sys_clk logic
// Notes:   host transfer engine lives outside; this block gates and flags it
`timescale 1ns/1ps
`include "twc_defines.vh"
module twc_top (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // register bus
  input  wire [7:0]  av_address,
  input  wire        av_read,
  input  wire        av_write,
  input  wire [31:0] av_writedata,
  input  wire [3:0]  av_byteenable,
  output reg  [31:0] av_readdata,
  output reg         av_waitrequest,
  // system state
  input  wire        sleep,
  input  wire        dbg_halt,
  input  wire        global_irq_enable,
  // host engine
  input  wire        host_rd_done,
  input  wire        host_wr_done,
  input  wire [5:0]  host_state,
  output reg         host_run,
  output reg         host_data_wr,
  output reg         host_data_rd,
  output reg  [1:0]  host_cmd,
  output reg         fast_plus,
  // interrupts
  output reg         client_irq,
  output reg         host_irq,
  output reg         irq,
  output reg         wake_req,
  // bus pins
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe_n,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_n
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_HOLD = 3'd2;
  localparam [2:0] S_ACK  = 3'd3;
  localparam [2:0] S_RX   = 3'd4;
  localparam [2:0] S_TX   = 3'd5;
  localparam [2:0] S_RACK = 3'd6;

  localparam integer CP = `TWC_CLK_PERIOD_NS;
  localparam integer HOLD_S = (`TWC_HOLD_SHORT_NS + CP - 1) / CP;
  localparam integer HOLD_M = (`TWC_HOLD_MID_NS + CP - 1) / CP;
  localparam integer HOLD_L = (`TWC_HOLD_LONG_NS + CP - 1) / CP;
  // done lands count+1 after start, scl released one edge later
  localparam integer SETUP_S = `TWC_SETUP_SHORT - 2;
  localparam integer SETUP_L = `TWC_SETUP_LONG - 2;

  function [5:0] hold_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'd1:    hold_cycles = HOLD_S[5:0];
        2'd2:    hold_cycles = HOLD_M[5:0];
        2'd3:    hold_cycles = HOLD_L[5:0];
        default: hold_cycles = 6'd0;
      endcase
    end
  endfunction

  // registers
  reg  [7:0] ctrl_q;
  reg        dbg_run_q;
  reg  [7:0] hctrla_q;
  reg        h_ackact_q;
  reg        rif_q;
  reg        wif_q;
  reg  [7:0] hbaud_q;
  reg  [7:0] haddr_q;
  reg  [7:0] hdata_q;
  reg  [7:0] cctrla_q;
  reg        c_ackact_q;
  reg        dif_q;
  reg        client_addr_or_stop_flag_q;
  reg        rxack_q;
  reg        dir_q;
  reg        ap_q;
  reg  [7:0] caddr_q;
  reg  [7:0] cdata_q;
  reg  [7:0] cmask_q;
  reg  [3:0] irq_mask_q;
  // client link
  reg  [2:0] st_q;
  reg  [2:0] nxt_q;
  reg  [2:0] bit_q;
  reg        byte_q;
  reg  [7:0] sh_q;
  reg        busy_q;
  reg        pend_q;
  reg        rel_q;

  wire [1:0] s_lvl;
  wire [1:0] s_rise;
  wire [1:0] s_fall;
  wire       hold_done;
  wire       setup_done;

  twc_sync #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin     ({scl_in, sda_in}),
    .level   (s_lvl),
    .rise    (s_rise),
    .fall    (s_fall)
  );

  wire scl_s    = s_lvl[1];
  wire sda_s    = s_lvl[0];
  wire scl_rise = s_rise[1];
  wire scl_fall = s_fall[1];
  wire start_c  = s_fall[0] & scl_s;
  wire stop_c   = s_rise[0] & scl_s;

  wire run_ok   = ~dbg_halt | dbg_run_q;
  wire dbg_quiet = dbg_halt & dbg_run_q;
  wire c_en     = cctrla_q[`TWC_EN_BIT] & run_ok;

  // bus access decode, accept on the cycle waitrequest is low
  wire [5:0] idx    = av_address[7:2];
  wire       mapped = av_address[1:0] == 2'b00 && idx <= `TWC_IDX_LAST;
  wire       acc    = (av_read | av_write) & ~av_waitrequest;
  wire       wr     = acc & av_write & av_byteenable[0] & mapped;
  wire       rd     = acc & av_read & mapped;
  wire [7:0] wd     = av_writedata[7:0];

  function wr_at;
    input [5:0] i;
    begin
      wr_at = wr && idx == i;
    end
  endfunction

  function rd_at;
    input [5:0] i;
    begin
      rd_at = rd && idx == i;
    end
  endfunction

  wire hdata_acc = (wr_at(`TWC_IDX_HDATA) | rd_at(`TWC_IDX_HDATA)) & ~dbg_quiet;
  wire cdata_acc = (wr_at(`TWC_IDX_CDATA) | rd_at(`TWC_IDX_CDATA)) & ~dbg_quiet;
  wire cdata_wr  = wr_at(`TWC_IDX_CDATA) & ~dbg_quiet;
  wire ccmd_wr   = wr_at(`TWC_IDX_CCTRLB) & (wd[1:0] != 2'b00);

  // client events
  wire [6:0] addr_diff = (sh_q[7:1] ^ caddr_q[7:1]) & ~cmask_q[7:1];
  wire       gen_call  = caddr_q[0] & (sh_q[7:1] == 7'h00);
  wire       matched   = (addr_diff == 7'h00) | gen_call;
  wire       hold_rel  = st_q == S_HOLD && ~rel_q &&
                         (nxt_q == S_TX ? cdata_wr : ccmd_wr);
  wire       hold_start = scl_fall && c_en && (st_q == S_ACK || st_q == S_TX);

  twc_delay #(.W(6)) u_hold (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (hold_start),
    .count   (hold_cycles(ctrl_q[`TWC_CTRL_HOLD_LO +: 2])),
    .done    (hold_done)
  );

  twc_delay #(.W(6)) u_setup (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (hold_rel),
    .count   (ctrl_q[`TWC_CTRL_SETUP] ? SETUP_L[5:0] : SETUP_S[5:0]),
    .done    (setup_done)
  );

  // flag set and clear terms
  wire set_dif  = c_en && ((scl_fall && st_q == S_RX && byte_q) ||
                  (hold_done && pend_q && st_q == S_ACK && dir_q) ||
                  (scl_fall && st_q == S_RACK));
  wire set_client_addr_or_stop_flag = c_en && ((scl_fall && st_q == S_ADDR && byte_q && matched) ||
                  (stop_c && st_q != S_IDLE && st_q != S_ADDR));
  wire set_rif  = host_run & host_rd_done;
  wire set_wif  = host_run & host_wr_done;
  wire smart    = cctrla_q[`TWC_SMART_BIT];
  wire clr_dif  = (wr_at(`TWC_IDX_CSTAT) & wd[`TWC_FLAG_HI]) | (cdata_acc & smart);
  wire clr_client_addr_or_stop_flag = wr_at(`TWC_IDX_CSTAT) & wd[`TWC_FLAG_LO];
  wire clr_rif  = (wr_at(`TWC_IDX_HSTAT) & wd[`TWC_FLAG_HI]) | hdata_acc;
  wire clr_wif  = (wr_at(`TWC_IDX_HSTAT) & wd[`TWC_FLAG_LO]) | hdata_acc;

  // registers and flags
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q     <= `TWC_RESET_VALUE;
      dbg_run_q  <= 1'b0;
      hctrla_q   <= `TWC_RESET_VALUE;
      h_ackact_q <= 1'b0;
      rif_q      <= 1'b0;
      wif_q      <= 1'b0;
      hbaud_q    <= `TWC_RESET_VALUE;
      haddr_q    <= `TWC_RESET_VALUE;
      hdata_q    <= `TWC_RESET_VALUE;
      cctrla_q   <= `TWC_RESET_VALUE;
      c_ackact_q <= 1'b0;
      dif_q      <= 1'b0;
      client_addr_or_stop_flag_q     <= 1'b0;
      caddr_q    <= `TWC_RESET_VALUE;
      cdata_q    <= `TWC_RESET_VALUE;
      cmask_q    <= `TWC_RESET_VALUE;
      irq_mask_q <= 4'h0;
    end else begin
      if (wr_at(`TWC_IDX_CTRL))
        ctrl_q <= wd & `TWC_CTRL_WMASK;
      if (wr_at(`TWC_IDX_DBG))
        dbg_run_q <= wd[`TWC_DBG_RUN];
      if (wr_at(`TWC_IDX_HCTRLA))
        hctrla_q <= wd & `TWC_HCTRLA_WMASK;
      if (wr_at(`TWC_IDX_HCTRLB))
        h_ackact_q <= wd[`TWC_ACKACT_BIT];
      if (wr_at(`TWC_IDX_HBAUD))
        hbaud_q <= wd;
      if (wr_at(`TWC_IDX_HADDR))
        haddr_q <= wd;
      if (wr_at(`TWC_IDX_HDATA))
        hdata_q <= wd;
      if (wr_at(`TWC_IDX_CCTRLA))
        cctrla_q <= wd & `TWC_CCTRLA_WMASK;
      if (wr_at(`TWC_IDX_CCTRLB))
        c_ackact_q <= wd[`TWC_ACKACT_BIT];
      if (wr_at(`TWC_IDX_CADDR))
        caddr_q <= wd;
      if (wr_at(`TWC_IDX_CDATA))
        cdata_q <= wd;
      else if (c_en && scl_fall && st_q == S_RX && byte_q)
        cdata_q <= sh_q;
      if (wr_at(`TWC_IDX_CMASK))
        cmask_q <= wd;
      if (wr_at(`TWC_IDX_IRQMASK))
        irq_mask_q <= wd[3:0];
      // set wins over clear
      dif_q  <= (dif_q & ~clr_dif) | set_dif;
      client_addr_or_stop_flag_q <= (client_addr_or_stop_flag_q & ~clr_client_addr_or_stop_flag) | set_client_addr_or_stop_flag;
      rif_q  <= (rif_q & ~clr_rif) | set_rif;
      wif_q  <= (wif_q & ~clr_wif) | set_wif;
    end
  end

  // client link machine
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q     <= S_IDLE;
      nxt_q    <= S_IDLE;
      bit_q    <= 3'd0;
      byte_q   <= 1'b0;
      sh_q     <= 8'h00;
      busy_q   <= 1'b0;
      pend_q   <= 1'b0;
      rel_q    <= 1'b0;
      rxack_q  <= 1'b0;
      dir_q    <= 1'b0;
      ap_q     <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      wake_req <= 1'b0;
    end else begin
      if (start_c)
        busy_q <= 1'b1;
      else if (stop_c)
        busy_q <= 1'b0;
      if (hold_start)
        pend_q <= 1'b1;
      else if (hold_done)
        pend_q <= 1'b0;
      wake_req <= sleep & st_q == S_HOLD;
      if (!c_en) begin
        st_q     <= S_IDLE;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
        rel_q    <= 1'b0;
      end else if (stop_c) begin
        if (st_q != S_IDLE && st_q != S_ADDR)
          ap_q <= 1'b0;
        st_q     <= S_IDLE;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
        rel_q    <= 1'b0;
      end else if (start_c) begin
        st_q     <= S_ADDR;
        bit_q    <= 3'd0;
        byte_q   <= 1'b0;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
        rel_q    <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              sh_q   <= {sh_q[6:0], sda_s};
              bit_q  <= bit_q + 3'd1;
              byte_q <= bit_q == 3'd7;
            end else if (scl_fall && byte_q) begin
              byte_q <= 1'b0;
              if (st_q == S_RX || matched) begin
                if (st_q == S_ADDR) begin
                  ap_q  <= 1'b1;
                  dir_q <= sh_q[0];
                end
                st_q     <= S_HOLD;
                nxt_q    <= S_ACK;
                scl_oe_n <= 1'b0;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_HOLD: begin
            if (hold_rel) begin
              rel_q <= 1'b1;
              if (nxt_q == S_TX) begin
                sh_q     <= wd;
                sda_oe_n <= wd[7];
                bit_q    <= 3'd0;
              end else begin
                sda_oe_n <= c_ackact_q;
              end
            end
            if (rel_q && setup_done && !sleep) begin
              scl_oe_n <= 1'b1;
              rel_q    <= 1'b0;
              st_q     <= nxt_q;
            end
          end
          S_ACK: begin
            if (hold_done && pend_q) begin
              sda_oe_n <= 1'b1;
              bit_q    <= 3'd0;
              byte_q   <= 1'b0;
              if (c_ackact_q) begin
                st_q <= S_IDLE;
              end else if (dir_q) begin
                st_q     <= S_HOLD;
                nxt_q    <= S_TX;
                scl_oe_n <= 1'b0;
              end else begin
                st_q <= S_RX;
              end
            end
          end
          S_TX: begin
            if (hold_done && pend_q) begin
              if (bit_q == 3'd7) begin
                sda_oe_n <= 1'b1;
                st_q     <= S_RACK;
              end else begin
                sh_q     <= {sh_q[6:0], 1'b0};
                sda_oe_n <= sh_q[6];
                bit_q    <= bit_q + 3'd1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise)
              rxack_q <= sda_s;
            else if (scl_fall) begin
              if (rxack_q) begin
                st_q <= S_IDLE;
              end else begin
                st_q     <= S_HOLD;
                nxt_q    <= S_TX;
                scl_oe_n <= 1'b0;
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // read mux
  reg [7:0] rdat;
  always @* begin
    case (idx)
      `TWC_IDX_CTRL:    rdat = ctrl_q;
      `TWC_IDX_DBG:     rdat = {7'h00, dbg_run_q};
      `TWC_IDX_HCTRLA:  rdat = hctrla_q;
      `TWC_IDX_HCTRLB:  rdat = {5'h00, h_ackact_q, 2'b00};
      `TWC_IDX_HSTAT:   rdat = {rif_q, wif_q, host_state};
      `TWC_IDX_HBAUD:   rdat = hbaud_q;
      `TWC_IDX_HADDR:   rdat = haddr_q;
      `TWC_IDX_HDATA:   rdat = hdata_q;
      `TWC_IDX_CCTRLA:  rdat = cctrla_q;
      `TWC_IDX_CCTRLB:  rdat = {5'h00, c_ackact_q, 2'b00};
      `TWC_IDX_CSTAT:   rdat = {dif_q, client_addr_or_stop_flag_q, st_q == S_HOLD, rxack_q,
                                2'b00, dir_q, ap_q};
      `TWC_IDX_CADDR:   rdat = caddr_q;
      `TWC_IDX_CDATA:   rdat = cdata_q;
      `TWC_IDX_CMASK:   rdat = cmask_q;
      `TWC_IDX_IRQMASK: rdat = {4'h0, irq_mask_q};
      default:          rdat = 8'h00;
    endcase
  end

  // bus answer, interrupts and host gating
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      av_waitrequest <= 1'b1;
      av_readdata    <= 32'h0000_0000;
      client_irq     <= 1'b0;
      host_irq       <= 1'b0;
      irq            <= 1'b0;
      host_run       <= 1'b0;
      host_data_wr   <= 1'b0;
      host_data_rd   <= 1'b0;
      host_cmd       <= 2'b00;
      fast_plus      <= 1'b0;
      scl_out        <= 1'b0;
      sda_out        <= 1'b0;
    end else begin
      av_waitrequest <= ~(av_waitrequest & (av_read | av_write));
      if (av_waitrequest && av_read)
        av_readdata <= {24'h00_0000, mapped ? rdat : 8'h00};
      client_irq <= (dif_q & cctrla_q[7]) | (client_addr_or_stop_flag_q & cctrla_q[6]);
      host_irq   <= global_irq_enable &
                    ((rif_q & hctrla_q[7]) | (wif_q & hctrla_q[6]));
      irq        <= |({wif_q, rif_q, client_addr_or_stop_flag_q, dif_q} & irq_mask_q);
      host_run   <= hctrla_q[`TWC_EN_BIT] & ~sleep & run_ok;
      host_data_wr <= wr_at(`TWC_IDX_HDATA) & ~dbg_quiet & host_run;
      host_data_rd <= rd_at(`TWC_IDX_HDATA) & ~dbg_quiet & host_run;
      host_cmd   <= (wr_at(`TWC_IDX_HCTRLB) & host_run) ? wd[1:0] : 2'b00;
      fast_plus  <= ctrl_q[`TWC_CTRL_FMP];
      scl_out    <= 1'b0;
      sda_out    <= 1'b0;
    end
  end
endmodule

// ### verilog/twc_defines.vh
// Purpose: constants for the two-wire common control block
// Assumes: 8-bit registers, each on one 32-bit word, byte address = 4 * index
// Notes:   timing figures are in ns or cycles as named
//
// How it works
// - client request line is high when client data flag or address/stop flag is set with its enable bit
// - host request line is high when host read flag or host write flag is set with its enable bit
// - every interrupt condition sets a flag in host or client status; address match and stop share one
// - bus state tracking and client address matching keep running while asleep
// - sleeping client matched after start holds scl low until clock returns
// - host side stops all operation while asleep
// - block runs in debug, halts with processor unless debug run is set
// - debug halt with debug run: data register access has no side effect
// - client setup select bit 4: four or eight cycles before scl release
// - sda hold field: off, about 50 ns, about 300 ns, about 500 ns
// - fast plus enable selects 1 MHz operation, clear means standard or fast
// - debug run clear: halted with processor and incoming events ignored
// - host read/write requests gated by own enable and global enable
`ifndef TWC_DEFINES_VH
`define TWC_DEFINES_VH

// register indices
`define TWC_IDX_CTRL      6'h00
`define TWC_IDX_DBG       6'h02
`define TWC_IDX_HCTRLA    6'h03
`define TWC_IDX_HCTRLB    6'h04
`define TWC_IDX_HSTAT     6'h05
`define TWC_IDX_HBAUD     6'h06
`define TWC_IDX_HADDR     6'h07
`define TWC_IDX_HDATA     6'h08
`define TWC_IDX_CCTRLA    6'h09
`define TWC_IDX_CCTRLB    6'h0a
`define TWC_IDX_CSTAT     6'h0b
`define TWC_IDX_CADDR     6'h0c
`define TWC_IDX_CDATA     6'h0d
`define TWC_IDX_CMASK     6'h0e
`define TWC_IDX_IRQMASK   6'h0f
`define TWC_IDX_LAST      6'h0f

// writable bits and reset values
`define TWC_CTRL_WMASK    8'h1e
`define TWC_HCTRLA_WMASK  8'hdf
`define TWC_CCTRLA_WMASK  8'he7
`define TWC_RESET_VALUE   8'h00

// field positions
`define TWC_CTRL_FMP      1
`define TWC_CTRL_HOLD_LO  2
`define TWC_CTRL_SETUP    4
`define TWC_DBG_RUN       0
`define TWC_EN_BIT        0
`define TWC_SMART_BIT     1
`define TWC_ACKACT_BIT    2
`define TWC_FLAG_HI       7
`define TWC_FLAG_LO       6

// timing
`define TWC_CLK_PERIOD_NS 8
`define TWC_HOLD_SHORT_NS 50
`define TWC_HOLD_MID_NS   300
`define TWC_HOLD_LONG_NS  500
`define TWC_SETUP_SHORT   4
`define TWC_SETUP_LONG    8

`endif

// ### verilog/twc_sync.v
// Purpose: two-flop synchroniser with edge detection for scl and sda
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module twc_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst_b,
  // pins
  input  wire [W-1:0] pin,
  // synchronised level and edges
  output reg  [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);
  reg [W-1:0] meta_q;
  reg [W-1:0] prev_q;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q <= {W{1'b1}};
      level  <= {W{1'b1}};
      prev_q <= {W{1'b1}};
    end else begin
      meta_q <= pin;
      level  <= meta_q;
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule

// ### verilog/twc_delay.v
// Purpose: one-shot cycle delay, pulses done count+1 cycles after start
// Assumes: start ignored while a delay runs
// Notes:   count of zero gives done on the next cycle
`timescale 1ns/1ps
module twc_delay #(
  parameter W = 6
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst_b,
  // control
  input  wire         start,
  input  wire [W-1:0] count,
  // result
  output reg          done
);
  reg [W-1:0] cnt_q;
  reg         run_q;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!run_q && start) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {W{1'b0}}) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule

// ### tb/twc_top_properties.sv
// Purpose: port-level checks for twc_top
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every twc_top instance
`timescale 1ns/1ps
module twc_top_properties (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_b,
  // register bus
  input wire [7:0]  av_address,
  input wire        av_write,
  input wire [31:0] av_writedata,
  input wire [3:0]  av_byteenable,
  input wire        av_waitrequest,
  // system state and outputs
  input wire        sleep,
  input wire        global_irq_enable,
  input wire        host_run,
  input wire        host_data_wr,
  input wire        fast_plus,
  input wire        host_irq,
  input wire        wake_req,
  input wire        scl_out,
  input wire        scl_oe_n,
  input wire        sda_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire wr_ok = av_write && !av_waitrequest && av_byteenable[0];
  wire wr_hd = wr_ok && av_address == 8'h20;
  wire wr_cc = wr_ok && av_address == 8'h00;

  AST_SLEEP_HOST: assert property (sleep |=> !host_run)
    else $error("host side runs while asleep");
  AST_GIE_GATE: assert property (!global_irq_enable |=> !host_irq)
    else $error("host request without global enable");
  AST_IRQ_CAUSE: assert property (host_irq |-> $past(global_irq_enable))
    else $error("host request not preceded by global enable");
  AST_FMP_SET: assert property (wr_cc && av_writedata[1] |-> ##[1:2] fast_plus)
    else $error("fast plus not set by write");
  AST_FMP_CLR: assert property (wr_cc && !av_writedata[1] |-> ##[1:2] !fast_plus)
    else $error("fast plus not cleared by write");
  AST_DATA_PULSE: assert property (host_data_wr |-> $past(wr_hd) || $past(wr_hd, 2))
    else $error("host data pulse without accepted write");
  AST_PULSE_ONE: assert property (host_data_wr |=> !host_data_wr)
    else $error("host data pulse longer than one cycle");
  AST_SLEEP_HOLD: assert property (sleep && !scl_oe_n |=> !scl_oe_n)
    else $error("clock hold dropped during sleep");
  AST_WAKE_END: assert property ($fell(sleep) |=> !wake_req)
    else $error("wake request outlives sleep");
  AST_OPEN_DRAIN: assert property (!scl_out && !sda_out)
    else $error("pin output data not low");
endmodule

bind twc_top twc_top_properties i_props (
  .sys_clk, .rst_b, .av_address, .av_write, .av_writedata, .av_byteenable,
  .av_waitrequest, .sleep, .global_irq_enable, .host_run, .host_data_wr,
  .fast_plus, .host_irq, .wake_req, .scl_out, .scl_oe_n, .sda_out
);

// ### tb/twc_bus_model.sv
// Purpose: remote host on the two-wire bus
// Assumes: 80 ns bit period, released lines pulled high
// Notes:   every high phase waits out clock stretching
`timescale 1ns/1ps
module twc_bus_model (
  // resolved wire levels
  input  wire  scl_line,
  input  wire  sda_line,
  // open-drain drives, 0 pulls low
  output logic scl_drv,
  output logic sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic scl_high;
    scl_drv = 1'b1;
    wait (scl_line === 1'b1);
  endtask

  // start, one byte msb first, then ack slot
  task automatic frame(input logic [7:0] b, output logic ack);
    sda_drv = 1'b0;
    #20 scl_drv = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #20 sda_drv = b[i];
      #20 scl_high;
      #40 scl_drv = 1'b0;
    end
    #20 sda_drv = 1'b1;
    #20 scl_high;
    #40 ack = sda_line;
    scl_drv = 1'b0;
  endtask

  task automatic stop;
    #20 sda_drv = 1'b0;
    #20 scl_high;
    #20 sda_drv = 1'b1;
    #20;
  endtask
endmodule

// ### tb/twc_top_tb_top.sv
// Purpose: self-checking bench for twc_top
// Assumes: twc_bus_model plays the remote host
// Notes:   bus waits are bounded; a watchdog ends a hang
`timescale 1ns/1ps
module twc_top_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  av_address = 8'h00;
  logic        av_read = 1'b0;
  logic        av_write = 1'b0;
  logic [31:0] av_writedata = 32'h0;
  logic        sleep = 1'b0;
  logic        dbg_halt = 1'b0;
  logic        gie = 1'b0;
  logic        rd_done = 1'b0;
  logic        wr_done = 1'b0;
  logic [31:0] av_readdata;
  logic        av_waitrequest, host_run, host_data_wr, host_data_rd, fast_plus;
  logic        client_irq, host_irq, irq, wake_req, ack;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, scl_drv, sda_drv;
  wire         scl_line = scl_drv & scl_oe_n;
  wire         sda_line = sda_drv & sda_oe_n;
  int          errors = 0;
  int          comparisons = 0;
  int          pulses = 0;
  int          n;
  logic [7:0]  v;

  initial forever #4 sys_clk = ~sys_clk;

  twc_top i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .av_address(av_address), .av_read(av_read),
    .av_write(av_write), .av_writedata(av_writedata), .av_byteenable(4'hf),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .sleep(sleep),
    .dbg_halt(dbg_halt), .global_irq_enable(gie), .host_rd_done(rd_done),
    .host_wr_done(wr_done), .host_state(6'h00), .host_run(host_run),
    .host_data_wr(host_data_wr), .host_data_rd(host_data_rd), .host_cmd(), .fast_plus(fast_plus),
    .client_irq(client_irq), .host_irq(host_irq), .irq(irq), .wake_req(wake_req),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n)
  );
  twc_bus_model i_host (.scl_line(scl_line), .sda_line(sda_line), .scl_drv(scl_drv),
    .sda_drv(sda_drv));

  always @(posedge sys_clk) if (host_data_wr === 1'b1 || host_data_rd === 1'b1) pulses <= pulses + 1;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // one register access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    av_address <= {idx, 2'b00};
    av_writedata <= {24'h0, wd};
    av_write <= wr;
    av_read <= !wr;
    @(posedge sys_clk);
    while (av_waitrequest !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 50) errors++;
    v = av_readdata[7:0];
    av_read <= 1'b0;
    av_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input string name, input logic [5:0] idx, input logic [7:0] m,
                     input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    check(name, v & m, e);
  endtask

  initial begin
    #400000;
    errors++;
    close_out;
  end

  initial begin
    tick(3);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 17; i++) rdc("reset value", i[5:0], 8'hff, 8'h00);
    bus(1'b1, 6'h00, 8'hff);
    rdc("common_control", 6'h00, 8'hff, 8'h1e);
    tick(2);
    check("fast_plus on", 8'(fast_plus), 8'h01);
    bus(1'b1, 6'h00, 8'h00);
    tick(2);
    check("fast_plus off", 8'(fast_plus), 8'h00);
    gie <= 1'b1;
    bus(1'b1, 6'h03, 8'hc1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 6'h0f, i == 0 ? 8'h0c : 8'h00);
      rd_done <= (i == 0);
      wr_done <= (i == 1);
      @(posedge sys_clk);
      rd_done <= 1'b0;
      wr_done <= 1'b0;
      tick(3);
      check("host_irq", 8'(host_irq), 8'h01);
      check("irq masked", 8'(irq), 8'(i == 0));
      rdc("host_status", 6'h05, 8'hc0, 8'h80 >> i);
      gie <= 1'b0;
      tick(3);
      check("host_irq gated", 8'(host_irq), 8'h00);
      gie <= 1'b1;
      bus(1'b1, 6'h05, 8'h80 >> i);
      tick(3);
      check("host_irq cleared", 8'(host_irq), 8'h00);
    end
    dbg_halt <= 1'b1;
    tick(3);
    check("host_run halted", 8'(host_run), 8'h00);
    bus(1'b1, 6'h02, 8'h01);
    tick(2);
    check("host_run debug", 8'(host_run), 8'h01);
    rd_done <= 1'b1;
    @(posedge sys_clk);
    rd_done <= 1'b0;
    n = pulses;
    bus(1'b1, 6'h08, 8'h5a);
    bus(1'b0, 6'h08, 8'h00);
    tick(3);
    check("quiet pulses", 8'(pulses - n), 8'h00);
    rdc("flag kept", 6'h05, 8'h80, 8'h80);
    dbg_halt <= 1'b0;
    bus(1'b1, 6'h08, 8'h5a);
    bus(1'b0, 6'h08, 8'h00);
    tick(3);
    check("data pulse", 8'(pulses - n), 8'h02);
    rdc("flag cleared", 6'h05, 8'h80, 8'h00);
    sleep <= 1'b1;
    tick(3);
    check("host_run asleep", 8'(host_run), 8'h00);
    sleep <= 1'b0;
    bus(1'b1, 6'h0c, 8'ha4);
    bus(1'b1, 6'h09, 8'hc1);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 6'h00, s ? 8'h10 : 8'h00);
      sleep <= (s == 0);
      fork
        i_host.frame(8'ha4, ack);
        begin
          n = 0;
          while (scl_oe_n !== 1'b0 && n < 400) begin
            @(posedge sys_clk);
            n++;
          end
          tick(20);
          check("scl held", 8'(scl_line), 8'h00);
          check("wake_req", 8'(wake_req), 8'(s == 0));
          sleep <= 1'b0;
          check("client_irq", 8'(client_irq), 8'h01);
          rdc("address match", 6'h0b, 8'h41, 8'h41);
          bus(1'b1, 6'h0b, 8'h40);
          tick(3);
          check("client_irq cleared", 8'(client_irq), 8'h00);
          bus(1'b1, 6'h0a, 8'h03);
          n = 0;
          while (scl_oe_n !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
          end
          check("setup cycles", n[7:0], s ? 8'd8 : 8'd4);
        end
      join
      check("ack bit", 8'(ack), 8'h00);
      i_host.stop;
      tick(10);
      rdc("stop seen", 6'h0b, 8'h41, 8'h40);
      check("lines free", {6'h0, scl_oe_n, sda_oe_n}, 8'h03);
      bus(1'b1, 6'h0b, 8'h40);
    end
    close_out;
  end
endmodule
